// ---- design/cnsr_pkg.sv ----
// Shared constants, states and helpers for the configuration save/restore block
package cnsr_pkg;
  // Serial port register space
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [11:0] ADDR_PIN_SEL = 12'h01D; // Status pin source select
  localparam logic [11:0] ADDR_APPLY = 12'h232; // Apply buffered settings
  localparam logic [11:0] ADDR_XFER_STATUS = 12'hB00; // nvm_transfer_status
  localparam logic [11:0] ADDR_DATA_ERROR = 12'hB01; // nvm_data_error
  localparam logic [11:0] ADDR_CONTROL = 12'hB02; // nvm_control
  localparam logic [11:0] ADDR_SAVE = 12'hB03; // nvm_save_trigger
  // Field positions
  localparam int BIT_PIN_SEL = 7;
  localparam int BIT_APPLY = 0;
  localparam int BIT_XFER_BUSY = 0;
  localparam int BIT_DATA_ERR = 0;
  localparam int BIT_WRITE_EN = 0;
  localparam int BIT_SOFT_RESTORE = 1;
  localparam int BIT_SAVE_GO = 0;
  // Reset values
  localparam logic RST_WRITE_EN = 1'h0; // Write protected by default
  localparam logic RST_PIN_SEL = 1'h0;
  localparam logic RST_LOAD_SEL = 1'h1; // Pin assumed high until sampled
  // Transfer direction
  localparam logic DIR_RESTORE = 1'h0;
  localparam logic DIR_SAVE = 1'h1;
  // Default number of configuration bytes moved per transfer
  localparam int NVM_BYTES = 64;

  // Transfer sequencer states
  typedef enum logic [3:0]
  {
    CNSR_IDLE = 4'h1,
    CNSR_LAUNCH = 4'h2,
    CNSR_WAIT = 4'h4,
    CNSR_FINISH = 4'h8
  } cnsr_state_t;

  // Running check byte, used both when saving and when restoring
  function automatic logic [7:0] cnsr_sum_add(input logic [7:0] sum, input logic [7:0] data);
    return sum + data;
  endfunction
endpackage

// ---- design/cnsr_nvm_engine.sv ----
// Byte sequencer moving the buffer bank to or from the nonvolatile memory
module cnsr_nvm_engine #(
  parameter int DEPTH = cnsr_pkg::NVM_BYTES,
  parameter int AW = $clog2(DEPTH + 1)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic dir,
  output logic busy,
  output logic done,
  output logic dataErr,
  // Nonvolatile memory port
  output logic nvmReq,
  output logic nvmWrite,
  output logic [AW-1:0] nvmAddr,
  output logic [7:0] nvmWdata,
  input wire logic nvmAck,
  input wire logic [7:0] nvmRdata,
  // Buffer register bank port
  output logic [AW-1:0] bufAddr,
  output logic bufWe,
  output logic [7:0] bufWdata,
  input wire logic [7:0] bufRdata
);
  // Last address holds the check byte
  localparam logic [AW-1:0] LAST = AW'(DEPTH);

  cnsr_pkg::cnsr_state_t state, next_state; // Sequencer state
  logic [AW-1:0] idx, next_idx; // Current byte index
  logic [7:0] sum, next_sum; // Running check byte
  logic dirQ, next_dirQ; // Latched direction
  logic next_busy, next_done, next_dataErr, next_nvmReq, next_nvmWrite, next_bufWe;
  logic [7:0] next_nvmWdata, next_bufWdata;
  logic [AW-1:0] next_bufAddr; // Buffer address, trails the index on restore writes

  // Memory side follows the index directly
  assign nvmAddr = idx;

  // Next-state logic of the sequencer
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_sum = sum;
    next_dirQ = dirQ;
    next_busy = busy;
    next_done = 1'b0;
    next_dataErr = dataErr;
    next_nvmReq = nvmReq;
    next_nvmWrite = nvmWrite;
    next_nvmWdata = nvmWdata;
    next_bufWe = 1'b0;
    next_bufWdata = bufWdata;
    case (state)
      cnsr_pkg::CNSR_IDLE:
      begin
        // New transfer clears the old error
        if (start)
        begin
          next_state = cnsr_pkg::CNSR_LAUNCH;
          next_idx = '0;
          next_sum = 8'h00;
          next_dirQ = dir;
          next_busy = 1'b1; // R1
          next_dataErr = 1'b0; // R3
        end
      end
      cnsr_pkg::CNSR_LAUNCH:
      begin
        // Buffer address has been stable one cycle, data is valid here
        next_nvmReq = 1'b1;
        next_nvmWrite = (dirQ == cnsr_pkg::DIR_SAVE); // R7
        next_nvmWdata = (idx == LAST) ? sum : bufRdata;
        if (dirQ == cnsr_pkg::DIR_SAVE && idx != LAST)
        begin
          next_sum = cnsr_pkg::cnsr_sum_add(sum, bufRdata);
        end
        next_state = cnsr_pkg::CNSR_WAIT;
      end
      cnsr_pkg::CNSR_WAIT:
      begin
        // Request held until the memory acknowledges
        if (nvmAck)
        begin
          next_nvmReq = 1'b0;
          next_nvmWrite = 1'b0;
          if (dirQ == cnsr_pkg::DIR_RESTORE)
          begin
            if (idx != LAST)
            begin
              next_bufWe = 1'b1;
              next_bufWdata = nvmRdata;
              next_sum = cnsr_pkg::cnsr_sum_add(sum, nvmRdata);
            end
            else
            begin
              next_dataErr = (nvmRdata != sum); // R3
            end
          end
          if (idx == LAST)
          begin
            next_state = cnsr_pkg::CNSR_FINISH;
          end
          else
          begin
            next_idx = idx + 1'b1;
            next_state = cnsr_pkg::CNSR_LAUNCH;
          end
        end
      end
      cnsr_pkg::CNSR_FINISH:
      begin
        // Busy drops together with the done pulse
        next_busy = 1'b0; // R1
        next_done = 1'b1;
        next_state = cnsr_pkg::CNSR_IDLE;
      end
      default:
      begin
        next_state = cnsr_pkg::CNSR_IDLE;
        next_busy = 1'b0;
        next_nvmReq = 1'b0;
      end
    endcase
    // A restore write pulse must land on the byte just read, not the next index
    next_bufAddr = next_bufWe ? idx : next_idx;
  end

  // Sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= cnsr_pkg::CNSR_IDLE;
      idx <= '0;
      sum <= 8'h00;
      dirQ <= cnsr_pkg::DIR_RESTORE;
      busy <= 1'b0;
      done <= 1'b0;
      dataErr <= 1'b0;
      nvmReq <= 1'b0;
      nvmWrite <= 1'b0;
      nvmWdata <= 8'h00;
      bufWe <= 1'b0;
      bufWdata <= 8'h00;
      bufAddr <= '0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      sum <= next_sum;
      dirQ <= next_dirQ;
      busy <= next_busy;
      done <= next_done;
      dataErr <= next_dataErr;
      nvmReq <= next_nvmReq;
      nvmWrite <= next_nvmWrite;
      nvmWdata <= next_nvmWdata;
      bufWe <= next_bufWe;
      bufWdata <= next_bufWdata;
      bufAddr <= next_bufAddr;
    end
  end
endmodule

// ---- design/cnsr_config_nvm.sv ----
// Configuration save/restore control registers, status pin and apply logic
//
// Operation
// R1: Pending flag high while transfer runs
// R2: Status pin shows pending flag when selected
// R3: Error flag set on bad restored data
// R4: Soft restore reloads settings when pin low
// R5: Soft restore bit clears next serial clock; code waits for an idle sequencer first
// R6: Memory writes blocked unless write enable set
// R7: Save trigger copies buffer, clears when done
// R8: Apply bit updates active registers, self-clears
// R9: Transfer end issues apply operation
// R10: Host polls pending flag, then checks error
module cnsr_config_nvm #(
  parameter int DEPTH = cnsr_pkg::NVM_BYTES,
  parameter int AW = $clog2(DEPTH + 1)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial port register access
  input wire logic sclkRise,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [cnsr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cnsr_pkg::DATA_W-1:0] regWdata,
  output logic [cnsr_pkg::DATA_W-1:0] regRdata,
  // Pins
  input wire logic nvmLoadSelPin,
  output logic statusPin,
  // Device actions
  output logic softResetOut,
  output logic applyOut,
  // Nonvolatile memory port
  output logic nvmReq,
  output logic nvmWrite,
  output logic [AW-1:0] nvmAddr,
  output logic [7:0] nvmWdata,
  input wire logic nvmAck,
  input wire logic [7:0] nvmRdata,
  // Buffer register bank port
  output logic [AW-1:0] bufAddr,
  output logic bufWe,
  output logic [7:0] bufWdata,
  input wire logic [7:0] bufRdata
);
  logic pinS1, pinS2, pinS3; // Pin synchroniser chain
  logic loadSel, next_loadSel; // Filtered load select level
  logic statusSel, next_statusSel; // Status pin source select
  logic writeEn, next_writeEn; // Memory write enable
  logic softRestore, next_softRestore; // Soft restore request bit
  logic saveTrigger, next_saveTrigger; // Save trigger bit
  logic applyReq, next_applyReq; // Apply request bit
  logic startGo, next_startGo; // One-cycle start to sequencer
  logic startDir, next_startDir; // Direction of that start
  logic next_statusPin, next_softResetOut, next_applyOut;
  logic [7:0] next_regRdata;
  logic engBusy, engDone, engErr; // Sequencer status
  logic busyAll; // Pending including the start cycle

  // Start cycle already counts as pending, so a read never sees a gap
  assign busyAll = engBusy | startGo;

  // Register writes, self-clearing bits and read mux
  always_comb
  begin
    next_statusSel = statusSel;
    next_writeEn = writeEn;
    next_softRestore = softRestore;
    next_saveTrigger = saveTrigger;
    next_applyReq = applyReq;
    next_startGo = 1'b0;
    next_startDir = startDir;
    next_softResetOut = 1'b0;
    next_applyOut = 1'b0;
    next_regRdata = regRdata;
    // Change counts once second and third stages agree
    next_loadSel = (pinS2 == pinS3) ? pinS3 : loadSel;
    // Clears first, so a set in the same cycle wins
    if (softRestore && sclkRise && !busyAll)
    begin
      // Waits for an idle sequencer rather than dropping the restore
      next_softRestore = 1'b0; // R5
      next_softResetOut = 1'b1; // R4
      next_startGo = 1'b1;
      next_startDir = cnsr_pkg::DIR_RESTORE;
    end
    if (applyReq && sclkRise)
    begin
      next_applyReq = 1'b0; // R8
      next_applyOut = 1'b1; // R8
    end
    if (engDone)
    begin
      next_saveTrigger = 1'b0; // R7
    end
    if (regWr)
    begin
      case (regAddr)
        cnsr_pkg::ADDR_PIN_SEL:
        begin
          next_statusSel = regWdata[cnsr_pkg::BIT_PIN_SEL];
        end
        cnsr_pkg::ADDR_CONTROL:
        begin
          next_writeEn = regWdata[cnsr_pkg::BIT_WRITE_EN]; // R6
          // Only honoured while the load select pin is low
          if (regWdata[cnsr_pkg::BIT_SOFT_RESTORE] && !loadSel)
          begin
            next_softRestore = 1'b1; // R4
          end
        end
        cnsr_pkg::ADDR_SAVE:
        begin
          // Protected or busy: the write is silently dropped
          if (regWdata[cnsr_pkg::BIT_SAVE_GO] && writeEn && !busyAll && !next_startGo)
          begin
            next_saveTrigger = 1'b1; // R7
            next_startGo = 1'b1; // R6
            next_startDir = cnsr_pkg::DIR_SAVE;
          end
        end
        cnsr_pkg::ADDR_APPLY:
        begin
          if (regWdata[cnsr_pkg::BIT_APPLY])
          begin
            next_applyReq = 1'b1; // R8
          end
        end
        default:
        begin
          next_applyReq = next_applyReq;
        end
      endcase
    end
    // Every finished transfer is followed by an apply
    if (engDone)
    begin
      next_applyReq = 1'b1; // R9
    end
    // Read data captured on the read strobe
    if (regRd)
    begin
      next_regRdata = 8'h00;
      case (regAddr)
        cnsr_pkg::ADDR_XFER_STATUS: next_regRdata[cnsr_pkg::BIT_XFER_BUSY] = busyAll; // R1
        cnsr_pkg::ADDR_DATA_ERROR: next_regRdata[cnsr_pkg::BIT_DATA_ERR] = engErr; // R3
        cnsr_pkg::ADDR_CONTROL:
        begin
          next_regRdata[cnsr_pkg::BIT_WRITE_EN] = writeEn;
          next_regRdata[cnsr_pkg::BIT_SOFT_RESTORE] = softRestore;
        end
        cnsr_pkg::ADDR_SAVE: next_regRdata[cnsr_pkg::BIT_SAVE_GO] = saveTrigger;
        cnsr_pkg::ADDR_PIN_SEL: next_regRdata[cnsr_pkg::BIT_PIN_SEL] = statusSel;
        cnsr_pkg::ADDR_APPLY: next_regRdata[cnsr_pkg::BIT_APPLY] = applyReq;
        default: next_regRdata = 8'h00;
      endcase
    end
    next_statusPin = statusSel & busyAll; // R2
  end

  // Control registers and pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pinS1 <= cnsr_pkg::RST_LOAD_SEL;
      pinS2 <= cnsr_pkg::RST_LOAD_SEL;
      pinS3 <= cnsr_pkg::RST_LOAD_SEL;
      loadSel <= cnsr_pkg::RST_LOAD_SEL;
      statusSel <= cnsr_pkg::RST_PIN_SEL;
      writeEn <= cnsr_pkg::RST_WRITE_EN;
      softRestore <= 1'b0;
      saveTrigger <= 1'b0;
      applyReq <= 1'b0;
      startGo <= 1'b0;
      startDir <= cnsr_pkg::DIR_RESTORE;
      statusPin <= 1'b0;
      softResetOut <= 1'b0;
      applyOut <= 1'b0;
      regRdata <= 8'h00;
    end
    else
    begin
      pinS1 <= nvmLoadSelPin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      loadSel <= next_loadSel;
      statusSel <= next_statusSel;
      writeEn <= next_writeEn;
      softRestore <= next_softRestore;
      saveTrigger <= next_saveTrigger;
      applyReq <= next_applyReq;
      startGo <= next_startGo;
      startDir <= next_startDir;
      statusPin <= next_statusPin;
      softResetOut <= next_softResetOut;
      applyOut <= next_applyOut;
      regRdata <= next_regRdata;
    end
  end

  // Byte sequencer
  cnsr_nvm_engine #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) engine (
    .clk(clk),
    .rstn(rstn),
    .start(startGo),
    .dir(startDir),
    .busy(engBusy),
    .done(engDone),
    .dataErr(engErr),
    .nvmReq(nvmReq),
    .nvmWrite(nvmWrite),
    .nvmAddr(nvmAddr),
    .nvmWdata(nvmWdata),
    .nvmAck(nvmAck),
    .nvmRdata(nvmRdata),
    .bufAddr(bufAddr),
    .bufWe(bufWe),
    .bufWdata(bufWdata),
    .bufRdata(bufRdata)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  xfer_busy_a: assert property (startGo |=> engBusy ##1 busyAll) else $error("pending not raised"); // R1
  xfer_end_a: assert property (engDone |-> !engBusy && $past(engBusy)) else $error("pending not cleared"); // R1
  status_pin_a: assert property (statusSel && busyAll && !regWr |=> statusPin) else $error("status pin low"); // R2
  pin_idle_a: assert property (!busyAll |=> !statusPin) else $error("status pin high while idle"); // R2
  err_clear_a: assert property (startGo |=> !engErr) else $error("error not cleared at start"); // R3
  soft_set_a: assert property (regWr && regAddr == cnsr_pkg::ADDR_CONTROL
    && regWdata[cnsr_pkg::BIT_SOFT_RESTORE] && !loadSel |=> softRestore) else $error("soft restore ignored"); // R4
  soft_clear_a: assert property (softRestore && sclkRise && !busyAll && !regWr
    |=> !softRestore && softResetOut && startGo && startDir == cnsr_pkg::DIR_RESTORE) else $error("soft restore stuck"); // R5
  write_protect_a: assert property (!writeEn && !startGo |=> !(startGo && startDir == cnsr_pkg::DIR_SAVE))
    else $error("save started while protected"); // R6
  save_clear_a: assert property (engDone && !regWr |=> !saveTrigger) else $error("save trigger not cleared"); // R7
  apply_pulse_a: assert property (applyReq && sclkRise && !engDone && !regWr |=> applyOut && !applyReq)
    else $error("apply not issued"); // R8
  apply_after_a: assert property (engDone |=> applyReq) else $error("no apply after transfer"); // R9

  save_done_c: cover property (startGo && startDir == cnsr_pkg::DIR_SAVE ##[1:1000] engDone);
  restore_done_c: cover property (softResetOut ##[1:1000] engDone);
  restore_err_c: cover property (engDone && engErr);
  apply_c: cover property (applyOut);
endmodule

// ---- verif/cnsr_nvm_model.sv ----
// Behavioural nonvolatile memory and buffer register bank facing the save/restore block
module cnsr_nvm_model #(
  parameter int DEPTH = 4,
  parameter int AW = 3
)
(
  // Clock
  input wire logic clk,
  // Bench knobs
  input wire logic [1:0] ackDelay,
  input wire logic corrupt,
  // Memory port
  input wire logic nvmReq,
  input wire logic nvmWrite,
  input wire logic [AW-1:0] nvmAddr,
  input wire logic [7:0] nvmWdata,
  output logic nvmAck,
  output logic [7:0] nvmRdata,
  // Buffer bank port
  input wire logic [AW-1:0] bufAddr,
  input wire logic bufWe,
  input wire logic [7:0] bufWdata,
  output logic [7:0] bufRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:DEPTH]; // Stored bytes plus check byte
  logic [7:0] bank [0:DEPTH]; // Buffer register bank
  int waitCnt = 0; // Cycles spent on the current request
  logic hold = 1'b0; // Blocks a second ack until the request drops
  initial nvmAck = 1'b0;
  initial nvmRdata = 8'h5A;
  assign bufRdata = bank[bufAddr];
  // Memory answers after a programmable wait, driven just after the edge
  always @(posedge clk)
  begin
    #1;
    nvmAck = 1'b0;
    // Released data toggles so stale bytes never look valid
    nvmRdata = ~nvmRdata;
    if (nvmReq !== 1'b1)
    begin
      hold = 1'b0;
      waitCnt = 0;
    end
    else if (!hold && waitCnt >= ackDelay)
    begin
      nvmAck = 1'b1;
      hold = 1'b1;
      if (nvmWrite)
        mem[nvmAddr] = nvmWdata;
      else
        nvmRdata = mem[nvmAddr] ^ {7'h00, corrupt && nvmAddr == '0};
    end
    else
      waitCnt++;
  end
  // Buffer bank write port
  always @(posedge clk)
  begin
    if (bufWe)
      bank[bufAddr] <= bufWdata;
  end
endmodule

// ---- verif/cnsr_config_nvm_tb.sv ----
// Self-checking bench for the configuration save/restore block
module cnsr_config_nvm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4; // Short transfers keep the run brief
  localparam int AW = 3;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sclkRise = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00;
  logic nvmLoadSelPin = 1'b0;
  logic [1:0] ackDelay = 2'h0;
  logic corrupt = 1'b0;
  logic [7:0] regRdata, nvmWdata, nvmRdata, bufWdata, bufRdata;
  logic statusPin, softResetOut, applyOut, nvmReq, nvmWrite, nvmAck, bufWe;
  logic [AW-1:0] nvmAddr, bufAddr;
  logic [31:0] lfsrState = 32'h291E; // Fixed seed for repeatable runs
  logic [1:0] sclkDiv = 2'h0;
  logic [7:0] rv;
  logic [11:0] resetAddr [5] = '{12'hB00, 12'hB01, 12'hB02, 12'hB03, 12'h123}; // Mapped plus one unmapped
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int applyCnt = 0;
  int resetCnt = 0;
  int writeCnt = 0;
  int base;
  int rb;
  cnsr_config_nvm #(.DEPTH(DEPTH), .AW(AW)) DUT (.clk(clk), .rstn(rstn), .sclkRise(sclkRise), .regWr(regWr),
    .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .nvmLoadSelPin(nvmLoadSelPin),
    .statusPin(statusPin), .softResetOut(softResetOut), .applyOut(applyOut), .nvmReq(nvmReq),
    .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmAck(nvmAck), .nvmRdata(nvmRdata),
    .bufAddr(bufAddr), .bufWe(bufWe), .bufWdata(bufWdata), .bufRdata(bufRdata));
  cnsr_nvm_model #(.DEPTH(DEPTH), .AW(AW)) partner (.clk(clk), .ackDelay(ackDelay), .corrupt(corrupt),
    .nvmReq(nvmReq), .nvmWrite(nvmWrite), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmAck(nvmAck),
    .nvmRdata(nvmRdata), .bufAddr(bufAddr), .bufWe(bufWe), .bufWdata(bufWdata), .bufRdata(bufRdata));
  always #5 clk = ~clk;
  // Serial clock rising edge every fourth cycle
  always @(posedge clk)
  begin
    #1;
    sclkDiv = sclkDiv + 2'h1;
    sclkRise = (sclkDiv == 2'h0);
  end
  // Pulse counters and hang watchdog
  always @(posedge clk)
  begin
    cycles++;
    applyCnt += (applyOut === 1'b1);
    resetCnt += (softResetOut === 1'b1);
    writeCnt += (nvmAck === 1'b1 && nvmWrite === 1'b1);
    if (cycles == 6000)
    begin
      n_errors++;
      complete_run();
    end
  end
  function automatic logic [7:0] rand_byte();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState[7:0];
  endfunction
  // Expected check byte: 8-bit sum of bank or memory bytes
  function automatic logic [7:0] exp_sum(input bit fromBank);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < DEPTH; i++)
      s += fromBank ? partner.bank[i] : partner.mem[i];
    return s;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge clk);
    #1 regWr = 1'b0;
  endtask
  // Read data lands on the edge after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 regRd = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1 regRd = 1'b0;
    d = regRdata;
  endtask
  // Host waits for the pending flag to drop, bounded
  task automatic poll();
    int i;
    for (i = 0; i < 300; i++)
    begin
      rd(12'hB00, rv);
      if (rv[0] === 1'b0)
        break;
    end
    check({7'h00, i == 300}, 8'h00, "pending never cleared");
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    for (int i = 0; i <= DEPTH; i++)
    begin
      partner.bank[i] = rand_byte();
      partner.mem[i] = rand_byte();
    end
    // Reset values, plus an unmapped address reading zero
    foreach (resetAddr[k])
    begin
      rd(resetAddr[k], rv);
      check(rv, 8'h00, "reset value");
    end
    $display("done: reset values");
    // Save refused while write protected
    wr(12'hB03, 8'h01);
    rd(12'hB03, rv);
    check(rv, 8'h00, "save trigger");
    repeat (20) @(posedge clk);
    check(8'(writeCnt), 8'h00, "protected writes");
    $display("done: write protect");
    // Save with status pin routed
    ackDelay = 2'(rand_byte());
    wr(12'h01D, 8'h80);
    wr(12'hB02, 8'h01);
    wr(12'hB03, 8'h01);
    base = applyCnt;
    rd(12'hB00, rv);
    check(rv, 8'h01, "pending");
    check({7'h00, statusPin}, 8'h01, "status pin");
    rd(12'hB03, rv);
    check(rv, 8'h01, "trigger held");
    poll();
    rd(12'hB03, rv);
    check(rv, 8'h00, "trigger cleared");
    rd(12'hB01, rv);
    check(rv, 8'h00, "error after save");
    for (int i = 0; i < DEPTH; i++)
      check(partner.mem[i], partner.bank[i], "saved byte");
    check(partner.mem[DEPTH], exp_sum(1), "check byte");
    repeat (8) @(posedge clk);
    check(8'(applyCnt - base), 8'h01, "apply after save");
    check({7'h00, statusPin}, 8'h00, "status idle");
    $display("done: save");
    // Restore, clean and then with a corrupted first byte
    wr(12'h01D, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < DEPTH; i++)
        partner.mem[i] = rand_byte();
      partner.mem[DEPTH] = exp_sum(0);
      ackDelay = 2'(rand_byte());
      corrupt = k[0];
      base = applyCnt;
      rb = resetCnt;
      wr(12'hB02, 8'h02);
      repeat (6) @(posedge clk);
      check({7'h00, statusPin}, 8'h00, "status unselected");
      poll();
      check(8'(resetCnt - rb), 8'h01, "soft reset pulse");
      rd(12'hB02, rv);
      check(rv, 8'h00, "soft restore cleared");
      rd(12'hB01, rv);
      check(rv, {7'h00, k[0]}, "data error");
      for (int i = 0; i < DEPTH; i++)
        check(partner.bank[i], partner.mem[i] ^ {7'h00, k[0] && i == 0}, "restored byte");
      repeat (8) @(posedge clk);
      check(8'(applyCnt - base), 8'h01, "apply after restore");
    end
    #1 corrupt = 1'b0;
    $display("done: restore");
    // Soft restore ignored while the load pin is high
    nvmLoadSelPin = 1'b1;
    rb = resetCnt;
    repeat (6) @(posedge clk);
    wr(12'hB02, 8'h02);
    repeat (12) @(posedge clk);
    check(8'(resetCnt - rb), 8'h00, "restore with pin high");
    rd(12'hB00, rv);
    check(rv, 8'h00, "no transfer");
    nvmLoadSelPin = 1'b0;
    $display("done: pin high");
    // Apply bit gives one pulse and clears itself
    base = applyCnt;
    wr(12'h232, 8'h01);
    repeat (8) @(posedge clk);
    check(8'(applyCnt - base), 8'h01, "apply pulse");
    rd(12'h232, rv);
    check(rv, 8'h00, "apply cleared");
    $display("done: apply");
    complete_run();
  end
endmodule
